// *** design/hdcr_drive_ctrl.sv ***
// Drive control registers with drive timing and input interpretation
//
// What this block does
// - Bit 7 of control A (reset 1) raises the loop gain while overdrive is active.
// - Bit 5 of control A (reset 0) drives a 0.9 V common-mode bias onto the input/trigger pin.
// - A 0 in the bias bit turns the bias drive off and a 1 turns it on.
// - Bits 4 to 0 of control A (reset 0x13) give the starting drive time in resonant mode.
// - In resonant mode the drive time is the setting times 0.1 ms plus 0.5 ms.
// - In resonant mode the drive time keeps tracking the actuator, the setting only seeds it.
// - In eccentric-mass mode the back-EMF sample period is the setting times 0.2 ms plus 1 ms.
// - Bit 7 of control B picks unidirectional (0) or bidirectional (1, reset) input data.
// - Unidirectional input brakes on feedback demand and uses the sign bit as extra amplitude.
// - Unidirectional input maps 0 to no drive, half to half scale and full to full scale.
// - Bidirectional open-loop input brakes below half, is idle at half and drives positive above.
// - Control B bits 5 to 4 pick a resonance sample interval of 150, 200, 250 or 300 us.
`timescale 1ns/1ps
`include "hdcr_consts.svh"
module hdcr_drive_ctrl #(
    parameter int unsigned LRA_BASE_CYC  = `HDCR_LRA_BASE_NS / `HDCR_CLK_PERIOD_NS,
    parameter int unsigned LRA_STEP_CYC  = `HDCR_LRA_STEP_NS / `HDCR_CLK_PERIOD_NS,
    parameter int unsigned ERM_BASE_CYC  = `HDCR_ERM_BASE_NS / `HDCR_CLK_PERIOD_NS,
    parameter int unsigned ERM_STEP_CYC  = `HDCR_ERM_STEP_NS / `HDCR_CLK_PERIOD_NS,
    parameter int unsigned SAMP_BASE_CYC = `HDCR_SAMP_BASE_NS / `HDCR_CLK_PERIOD_NS,
    parameter int unsigned SAMP_STEP_CYC = `HDCR_SAMP_STEP_NS / `HDCR_CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Serial register port
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Playback engine status
    input  wire logic        lra_mode,
    input  wire logic        closed_loop,
    input  wire logic        drive_active,
    input  wire logic [7:0]  input_level,
    input  wire logic        brake_request,
    input  wire logic        zero_cross,
    // Configuration out to the loop and front end
    output logic             overdrive_gain_boost,
    output logic             input_common_mode_bias,
    output logic             brake_gain_taper,
    output logic [1:0]       blanking_interval,
    output logic [1:0]       current_decay_interval,
    // Drive timing and amplitude
    output logic [19:0]      drive_period,
    output logic             period_tick,
    output logic             resonance_sample_tick,
    output logic [7:0]       drive_mag,
    output logic             drive_neg,
    output logic             brake_active
);
    // ****************************************
    // Register bank
    // ****************************************
    hdcr_regbus_if bus ();

    hdcr_ser_port u_ser (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .bus    (bus.port)
    );

    logic [7:0] ctrl_a_r, ctrl_a_nxt;
    logic [7:0] ctrl_b_r, ctrl_b_nxt;

    always_comb begin
        ctrl_a_nxt = ctrl_a_r;
        ctrl_b_nxt = ctrl_b_r;
        if (bus.wr_stb && bus.addr == `HDCR_OFF_CTRL_A) begin
            ctrl_a_nxt = bus.wdata & `HDCR_CTRL_A_RD_MASK;
        end else if (bus.wr_stb && bus.addr == `HDCR_OFF_CTRL_B) begin
            ctrl_b_nxt = bus.wdata;
        end
    end

    // Unmapped offsets read as zero
    always_comb begin
        if (bus.addr == `HDCR_OFF_CTRL_A) begin
            bus.rdata = ctrl_a_r & `HDCR_CTRL_A_RD_MASK;
        end else if (bus.addr == `HDCR_OFF_CTRL_B) begin
            bus.rdata = ctrl_b_r;
        end else begin
            bus.rdata = 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_a_r <= `HDCR_CTRL_A_RST;
            ctrl_b_r <= `HDCR_CTRL_B_RST;
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
        end else if (ce) begin
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_b_r <= ctrl_b_nxt;
            sda_out  <= 1'b0;
            sda_oe   <= bus.sda_oe;
        end
    end

    // Open-drain pin only ever pulls low; the port flop adds one cycle before the pin moves
    assign overdrive_gain_boost   = ctrl_a_r[`HDCR_BOOST_BIT];
    assign input_common_mode_bias = ctrl_a_r[`HDCR_BIAS_BIT];
    assign brake_gain_taper       = ctrl_b_r[`HDCR_TAPER_BIT];
    assign blanking_interval      = ctrl_b_r[`HDCR_BLANK_MSB:`HDCR_BLANK_LSB];
    assign current_decay_interval = ctrl_b_r[`HDCR_DECAY_MSB:`HDCR_DECAY_LSB];

    // ****************************************
    // Drive period and tracking
    // ****************************************
    logic [4:0]  dt_set;
    logic [19:0] seed;
    logic [19:0] period_r, period_nxt;
    logic [19:0] meas_r, meas_nxt;
    logic [19:0] tmr_r, tmr_nxt;
    logic        ptick_r, ptick_nxt;

    assign dt_set = ctrl_a_r[`HDCR_DT_MSB:`HDCR_DT_LSB];

    always_comb begin
        if (lra_mode) begin
            seed = 20'(LRA_BASE_CYC + 32'(dt_set) * LRA_STEP_CYC);
        end else begin
            seed = 20'(ERM_BASE_CYC + 32'(dt_set) * ERM_STEP_CYC);
        end
    end

    // Tracking averages the old estimate with each measured half period, trading speed for noise immunity
    always_comb begin
        period_nxt = period_r;
        meas_nxt   = meas_r;
        tmr_nxt    = 20'h00000;
        ptick_nxt  = 1'b0;
        if (!drive_active || !lra_mode) begin
            period_nxt = seed;
            meas_nxt   = 20'h00000;
        end else if (zero_cross) begin
            period_nxt = 20'(({1'b0, period_r} + {1'b0, meas_r}) >> 1);
            meas_nxt   = 20'h00001;
        end else if (meas_r != 20'hfffff) begin
            meas_nxt = meas_r + 20'h00001;
        end
        if (drive_active) begin
            if (tmr_r >= period_r - 20'h00001) begin
                ptick_nxt = 1'b1;
            end else begin
                tmr_nxt = tmr_r + 20'h00001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            period_r <= 20'h00000;
            meas_r   <= 20'h00000;
            tmr_r    <= 20'h00000;
            ptick_r  <= 1'b0;
        end else if (ce) begin
            period_r <= period_nxt;
            meas_r   <= meas_nxt;
            tmr_r    <= tmr_nxt;
            ptick_r  <= ptick_nxt;
        end
    end

    assign drive_period = period_r;
    assign period_tick  = ptick_r;

    // ****************************************
    // Resonance sample interval
    // ****************************************
    logic [15:0] samp_lim;
    logic [15:0] scnt_r, scnt_nxt;
    logic        stick_r, stick_nxt;

    assign samp_lim = 16'(SAMP_BASE_CYC + 32'(ctrl_b_r[`HDCR_SAMP_MSB:`HDCR_SAMP_LSB]) * SAMP_STEP_CYC);

    always_comb begin
        scnt_nxt  = 16'h0000;
        stick_nxt = 1'b0;
        if (drive_active && lra_mode) begin
            if (scnt_r >= samp_lim - 16'h0001) begin
                stick_nxt = 1'b1;
            end else begin
                scnt_nxt = scnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            scnt_r  <= 16'h0000;
            stick_r <= 1'b0;
        end else if (ce) begin
            scnt_r  <= scnt_nxt;
            stick_r <= stick_nxt;
        end
    end

    assign resonance_sample_tick = stick_r;

    // ****************************************
    // Input interpretation
    // ****************************************
    logic [7:0] mag_r, mag_nxt;
    logic       neg_r, neg_nxt;
    logic       brk_r, brk_nxt;
    logic       bidir;

    assign bidir = ctrl_b_r[`HDCR_SIGNED_BIT];

    always_comb begin
        mag_nxt = 8'h00;
        neg_nxt = 1'b0;
        brk_nxt = brake_request;
        if (!bidir) begin
            mag_nxt = input_level;
        end else if (!closed_loop) begin
            brk_nxt = input_level < `HDCR_MID_LEVEL;
            if (input_level < `HDCR_MID_LEVEL) begin
                mag_nxt = {~input_level[6:0], 1'b1};
                neg_nxt = 1'b1;
            end else begin
                mag_nxt = {input_level[6:0], 1'b0};
            end
        end else if (input_level > `HDCR_MID_LEVEL) begin
            mag_nxt = {input_level[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mag_r <= 8'h00;
            neg_r <= 1'b0;
            brk_r <= 1'b0;
        end else if (ce) begin
            mag_r <= mag_nxt;
            neg_r <= neg_nxt;
            brk_r <= brk_nxt;
        end
    end

    assign drive_mag    = mag_r;
    assign drive_neg    = neg_r;
    assign brake_active = brk_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Antecedents need reset already released when sampled: the flops still take reset on the releasing edge
    logic        run;
    logic [15:0] sgap_r;
    logic        sarm_r;
    assign run = ce && resetn;

    // Cycles since the last sample tick; any register write disarms it since the interval may change
    always_ff @(posedge clock) begin
        if (!resetn || !drive_active || !lra_mode) begin
            sgap_r <= 16'h0000;
            sarm_r <= 1'b0;
        end else if (ce) begin
            sgap_r <= stick_r ? 16'h0001 : sgap_r + 16'h0001;
            sarm_r <= (sarm_r || stick_r) && !bus.wr_stb;
        end
    end

    sequence s_write_a;
        run && bus.wr_stb && bus.addr == `HDCR_OFF_CTRL_A;
    endsequence

    chk_boost_write: assert property (s_write_a |=> overdrive_gain_boost == $past(bus.wdata[`HDCR_BOOST_BIT]))
        else $error("gain boost does not follow write");
    chk_bias_write: assert property (s_write_a |=> input_common_mode_bias == $past(bus.wdata[`HDCR_BIAS_BIT]))
        else $error("bias enable does not follow write");
    chk_reserved_zero: assert property (bus.addr == `HDCR_OFF_CTRL_A |-> !bus.rdata[6] && !ctrl_a_r[6])
        else $error("reserved bit not zero");
    chk_reset_values: assert property (disable iff (1'b0) !resetn
        |=> ctrl_a_r == `HDCR_CTRL_A_RST && ctrl_b_r == `HDCR_CTRL_B_RST)
        else $error("register reset value wrong");
    chk_lra_seed: assert property (run && !drive_active && lra_mode
        |=> period_r == 20'(LRA_BASE_CYC + 32'($past(dt_set)) * LRA_STEP_CYC))
        else $error("resonant drive time seed wrong");
    chk_erm_period: assert property (run && !lra_mode
        |=> period_r == 20'(ERM_BASE_CYC + 32'($past(dt_set)) * ERM_STEP_CYC))
        else $error("back-EMF sample period wrong");
    chk_track_avg: assert property (run && drive_active && lra_mode && zero_cross
        |=> period_r == 20'(({1'b0, $past(period_r)} + {1'b0, $past(meas_r)}) >> 1))
        else $error("drive time not tracking");
    chk_unidir_map: assert property (run && !bidir |=> drive_mag == $past(input_level) && !drive_neg
        && brake_active == $past(brake_request))
        else $error("unidirectional mapping wrong");
    chk_bidir_open: assert property (run && bidir && !closed_loop && input_level == `HDCR_MID_LEVEL
        |=> drive_mag == 8'h00 && !brake_active)
        else $error("mid-scale input not idle");
    chk_bidir_brake: assert property (run && bidir && !closed_loop && input_level == 8'h00
        |=> drive_mag == 8'hff && drive_neg && brake_active)
        else $error("zero input not full braking");
    chk_sample_gap: assert property (stick_r && sarm_r |-> sgap_r == samp_lim)
        else $error("sample interval wrong");
endmodule

// *** design/hdcr_consts.svh ***
// Offsets, field positions, reset values and timing figures of the drive control registers
`ifndef HDCR_CONSTS_SVH
`define HDCR_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define HDCR_OFF_CTRL_A      8'h1b
`define HDCR_OFF_CTRL_B      8'h1c
`define HDCR_CTRL_A_RST      8'h93
`define HDCR_CTRL_B_RST      8'hf5
`define HDCR_CTRL_A_RD_MASK  8'hbf

// ****************************************
// Field positions
// ****************************************
`define HDCR_BOOST_BIT       7
`define HDCR_RSVD_BIT        6
`define HDCR_BIAS_BIT        5
`define HDCR_DT_MSB          4
`define HDCR_DT_LSB          0
`define HDCR_SIGNED_BIT      7
`define HDCR_TAPER_BIT       6
`define HDCR_SAMP_MSB        5
`define HDCR_SAMP_LSB        4
`define HDCR_BLANK_MSB       3
`define HDCR_BLANK_LSB       2
`define HDCR_DECAY_MSB       1
`define HDCR_DECAY_LSB       0

// ****************************************
// Serial port
// ****************************************
// Arbitrary device address, not tied to any real part
`define HDCR_DEV_ADDR        7'h2d
`define HDCR_BYTE_BITS       4'h8

// ****************************************
// Playback levels
// ****************************************
`define HDCR_MID_LEVEL       8'h80

// ****************************************
// Timing, in ns, and clock period
// ****************************************
`define HDCR_CLK_PERIOD_NS   8
`define HDCR_LRA_BASE_NS     500000
`define HDCR_LRA_STEP_NS     100000
`define HDCR_ERM_BASE_NS     1000000
`define HDCR_ERM_STEP_NS     200000
`define HDCR_SAMP_BASE_NS    150000
`define HDCR_SAMP_STEP_NS    50000

`endif

// *** design/hdcr_pkg.sv ***
// Types shared by the drive control register block
package hdcr_pkg;
    typedef enum logic [3:0] {
        HDCR_ST_IDLE,
        HDCR_ST_ADDR,
        HDCR_ST_ACK_ADDR,
        HDCR_ST_PTR,
        HDCR_ST_ACK_PTR,
        HDCR_ST_WDATA,
        HDCR_ST_ACK_W,
        HDCR_ST_RDATA,
        HDCR_ST_ACK_R
    } hdcr_ser_state_t;
endpackage

// *** design/hdcr_regbus_if.sv ***
// Register access path between the serial port and the register bank
`timescale 1ns/1ps
interface hdcr_regbus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic [7:0] rdata;
    logic       sda_oe;

    modport port (output addr, output wdata, output wr_stb, output sda_oe, input rdata);
    modport bank (input addr, input wdata, input wr_stb, input sda_oe, output rdata);
endinterface

// *** design/hdcr_ser_port.sv ***
// Two-wire serial slave that turns bus transfers into register writes and reads
`timescale 1ns/1ps
`include "hdcr_consts.svh"
module hdcr_ser_port (
    // Clock, reset and enable
    input  wire logic    clock,
    input  wire logic    resetn,
    input  wire logic    ce,
    // Serial pins
    input  wire logic    scl_in,
    input  wire logic    sda_in,
    // Register side
    hdcr_regbus_if.port  bus
);
    hdcr_pkg::hdcr_ser_state_t st_r, st_nxt;
    logic [2:0] scl_r, scl_nxt;
    logic [2:0] sda_r, sda_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] wdat_r, wdat_nxt;
    logic       wr_r, wr_nxt;
    logic       oe_r, oe_nxt;
    logic       rw_r, rw_nxt;
    logic       nack_r, nack_nxt;
    logic       scl_rise, scl_fall, start, stop;

    // Stage 0 only feeds stage 1; edges are taken between stages 1 and 2
    assign scl_rise = scl_r[1] & ~scl_r[2];
    assign scl_fall = ~scl_r[1] & scl_r[2];
    assign start    = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
    assign stop     = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];

    assign bus.addr   = ptr_r;
    assign bus.wdata  = wdat_r;
    assign bus.wr_stb = wr_r;
    assign bus.sda_oe = oe_r;

    always_comb begin
        scl_nxt  = {scl_r[1:0], scl_in};
        sda_nxt  = {sda_r[1:0], sda_in};
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        ptr_nxt  = ptr_r;
        wdat_nxt = wdat_r;
        wr_nxt   = 1'b0;
        oe_nxt   = oe_r;
        rw_nxt   = rw_r;
        nack_nxt = nack_r;
        if (start) begin
            st_nxt  = hdcr_pkg::HDCR_ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else if (stop) begin
            st_nxt = hdcr_pkg::HDCR_ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                hdcr_pkg::HDCR_ST_ADDR, hdcr_pkg::HDCR_ST_PTR, hdcr_pkg::HDCR_ST_WDATA: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[6:0], sda_r[1]};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == `HDCR_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        oe_nxt  = 1'b1;
                        if (st_r == hdcr_pkg::HDCR_ST_ADDR) begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] == `HDCR_DEV_ADDR) begin
                                st_nxt = hdcr_pkg::HDCR_ST_ACK_ADDR;
                            end else begin
                                oe_nxt = 1'b0;
                                st_nxt = hdcr_pkg::HDCR_ST_IDLE;
                            end
                        end else if (st_r == hdcr_pkg::HDCR_ST_PTR) begin
                            ptr_nxt = sh_r;
                            st_nxt  = hdcr_pkg::HDCR_ST_ACK_PTR;
                        end else begin
                            wr_nxt   = 1'b1;
                            wdat_nxt = sh_r;
                            st_nxt   = hdcr_pkg::HDCR_ST_ACK_W;
                        end
                    end
                end
                hdcr_pkg::HDCR_ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            sh_nxt  = bus.rdata;
                            oe_nxt  = ~bus.rdata[7];
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt  = hdcr_pkg::HDCR_ST_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = hdcr_pkg::HDCR_ST_PTR;
                        end
                    end
                end
                hdcr_pkg::HDCR_ST_ACK_PTR, hdcr_pkg::HDCR_ST_ACK_W: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        st_nxt = hdcr_pkg::HDCR_ST_WDATA;
                        if (st_r == hdcr_pkg::HDCR_ST_ACK_W) begin
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                hdcr_pkg::HDCR_ST_RDATA: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[6:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == `HDCR_BYTE_BITS) begin
                            oe_nxt  = 1'b0;
                            cnt_nxt = 4'h0;
                            st_nxt  = hdcr_pkg::HDCR_ST_ACK_R;
                        end else begin
                            oe_nxt = ~sh_r[7];
                        end
                    end
                end
                hdcr_pkg::HDCR_ST_ACK_R: begin
                    if (scl_rise) begin
                        nack_nxt = sda_r[1];
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            st_nxt = hdcr_pkg::HDCR_ST_IDLE;
                        end else begin
                            sh_nxt  = bus.rdata;
                            oe_nxt  = ~bus.rdata[7];
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt  = hdcr_pkg::HDCR_ST_RDATA;
                        end
                    end
                end
                default: begin
                    st_nxt = hdcr_pkg::HDCR_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r   <= hdcr_pkg::HDCR_ST_IDLE;
            scl_r  <= 3'h7;
            sda_r  <= 3'h7;
            cnt_r  <= 4'h0;
            sh_r   <= 8'h00;
            ptr_r  <= 8'h00;
            wdat_r <= 8'h00;
            wr_r   <= 1'b0;
            oe_r   <= 1'b0;
            rw_r   <= 1'b0;
            nack_r <= 1'b0;
        end else if (ce) begin
            st_r   <= st_nxt;
            scl_r  <= scl_nxt;
            sda_r  <= sda_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            ptr_r  <= ptr_nxt;
            wdat_r <= wdat_nxt;
            wr_r   <= wr_nxt;
            oe_r   <= oe_nxt;
            rw_r   <= rw_nxt;
            nack_r <= nack_nxt;
        end
    end
endmodule

// *** test/hdcr_host_model.sv ***
// Host-side serial master that reaches the drive control registers
`timescale 1ns/1ps
`include "hdcr_consts.svh"
module hdcr_host_model (
    // Clock and data line level
    input  wire logic clock,
    input  wire logic sda_line,
    // Serial pins driven by the host
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Eight cycles a phase keeps well clear of the four-cycle minimum
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tk(8);
        scl <= 1'b1;
        tk(8);
        r = sda_line;
        scl <= 1'b0;
        tk(8);
    endtask
    // Ninth slot always released: ACK from the device, NACK on reads
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, a);
        ack = !a;
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tk(8);
        scl <= 1'b1;
        tk(8);
        sda_low <= 1'b1;
        tk(8);
        scl <= 1'b0;
        tk(8);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tk(8);
        scl <= 1'b1;
        tk(8);
        sda_low <= 1'b0;
        tk(8);
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2;
        start();
        xfer({`HDCR_DEV_ADDR, 1'b0}, q, a0);
        xfer(off, q, a1);
        xfer(d, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start();
        xfer({`HDCR_DEV_ADDR, 1'b0}, q, a);
        xfer(off, q, a);
        start();
        xfer({`HDCR_DEV_ADDR, 1'b1}, q, a);
        xfer(8'hff, d, a);
        stop();
    endtask
endmodule

// *** test/test_haptic_drive_control_regs.sv ***
// Self-checking bench for the drive control registers
`timescale 1ns/1ps
module test_haptic_drive_control_regs;
    logic        clock = 1'b0, resetn = 1'b0, lra = 1'b0, cl = 1'b0, act = 1'b0, brk = 1'b0;
    logic        ce = 1'b1, zc = 1'b0, sda_out;
    logic [7:0]  lvl = 8'h00;
    logic        scl, sda_low, sda_oe, boost, bias, taper, ptick, stick, neg, brake, ok;
    logic [1:0]  blank, decay;
    logic [19:0] period;
    logic [7:0]  mag, q;
    int          bad_count = 0, n_checks = 0;
    wire logic   sda_line = !(sda_low | sda_oe);
    // Shortened timing so every interval fits in a short run
    localparam int LB = 50, LS = 10, EB = 100, ES = 20, SB = 30, SS = 10;
    hdcr_drive_ctrl #(.LRA_BASE_CYC(LB), .LRA_STEP_CYC(LS), .ERM_BASE_CYC(EB), .ERM_STEP_CYC(ES),
        .SAMP_BASE_CYC(SB), .SAMP_STEP_CYC(SS)) dut (.clock(clock), .resetn(resetn), .ce(ce),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .lra_mode(lra), .closed_loop(cl),
        .drive_active(act), .input_level(lvl), .brake_request(brk), .zero_cross(zc),
        .overdrive_gain_boost(boost), .input_common_mode_bias(bias), .brake_gain_taper(taper),
        .blanking_interval(blank), .current_decay_interval(decay), .drive_period(period),
        .period_tick(ptick), .resonance_sample_tick(stick), .drive_mag(mag), .drive_neg(neg),
        .brake_active(brake));
    hdcr_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    always #4 clock = ~clock;
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic setin(input logic m, input logic c, input logic a, input logic [7:0] l, input logic b);
        @(posedge clock);
        {lra, cl, act, lvl, brk} <= {m, c, a, l, b};
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic gap(input logic s, input int e);
        int n;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while ((s ? stick : ptick) !== 1'b1 && n < 3000);
        end
        chk(20'(n), 20'(e));
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        host.rd(8'h1b, q);
        chk(q, 8'h93);
        host.rd(8'h1c, q);
        chk(q, 8'hf5);
        chk({boost, bias, taper, blank, decay, sda_out}, 8'haa);
    endtask
    task automatic t_ctrl_a();
        host.wr(8'h1b, 8'h7f, ok);
        host.rd(8'h1b, q);
        chk(q, 8'h3f);
        chk({ok, boost, bias}, 3'b101);
        chk(period, 20'd720);
        setin(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
        chk(period, 20'd360);
        host.wr(8'h1e, 8'hff, ok);
        host.rd(8'h1e, q);
        chk(q, 8'h00);
        host.wr(8'h1b, 8'h80, ok);
        chk({boost, bias, period}, {2'b10, 20'd50});
    endtask
    task automatic t_ticks();
        setin(1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
        gap(1'b0, 100);
        // The resonant seed is taken only while playback is idle
        setin(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
        setin(1'b1, 1'b0, 1'b1, 8'h00, 1'b0);
        gap(1'b0, 50);
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h1c, {2'b11, 2'(c), 4'h5}, ok);
            gap(1'b1, 30 + 10 * c);
        end
    endtask
    task automatic t_track();
        setin(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
        @(posedge clock);
        act <= 1'b1;
        repeat (70) @(posedge clock);
        zc <= 1'b1;
        @(posedge clock);
        zc <= 1'b0;
        @(posedge clock);
        #1;
        chk(period, 20'd60);
        gap(1'b0, 60);
    endtask
    task automatic t_map();
        logic [7:0] lv[3] = '{8'h00, 8'h80, 8'hff};
        logic [9:0] ex[3] = '{10'h3ff, 10'h000, 10'h3f8};
        host.wr(8'h1c, 8'h75, ok);
        setin(1'b0, 1'b1, 1'b0, 8'h80, 1'b1);
        chk({mag, neg, brake}, 10'h201);
        host.wr(8'h1c, 8'hf5, ok);
        for (int i = 0; i < 3; i++) begin
            setin(1'b0, 1'b0, 1'b0, lv[i], 1'b0);
            chk({mag, neg, brake}, ex[i]);
        end
        setin(1'b0, 1'b1, 1'b0, 8'h40, 1'b1);
        chk({mag, neg, brake}, 10'h001);
        setin(1'b0, 1'b1, 1'b0, 8'hc0, 1'b0);
        chk({mag, neg, brake}, 10'h200);
        // With the enable low nothing may move
        @(posedge clock);
        ce <= 1'b0;
        setin(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
        chk({mag, neg, brake}, 10'h200);
        @(posedge clock);
        ce <= 1'b1;
        setin(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
        chk({mag, neg, brake}, 10'h3ff);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_ctrl_a();
        t_ticks();
        t_track();
        t_map();
        end_of_test();
    end
    // Roughly five times the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        end_of_test();
    end
endmodule
